// >>> verilog/fofl_pkg.sv
// package: constants and types for the flag offset loader and port A decode
// Operation
// - select 2 latched at reset: high plain parity, low interspersed parity
// - first four FIFO1 writes load full1, empty1, full2, empty2 in order
// - plain parity offset uses contiguous port A bits from bit 0
// - interspersed parity offset skips port A bit 8
// - highest port A bit used is offset msb
// - after four parallel writes port B ready goes high, normal operation
// - preset offset chosen by three selects at master reset
// - serial load chosen by selects low, high, low at both resets
// - serial bits shift msb first from full1 through to empty2
// - port A ready low during serial load, high edge after last bit
// - port B ready low until all serial bits written
// - port B ready rises on clock edge after last serial bit
// - one serial bit per clock while serial enable low
// - port A bus floats on select high, direction picks in or out
// - mailbox high: write mailbox 1 or read mailbox 2 setting its flag
// - FIFO1 write only while port A ready high
package fofl_pkg;
  // ****************************************
  // offsets and presets
  // ****************************************
  localparam int OFS_W = 13;
  localparam logic [OFS_W-1:0] PRESET_64   = 13'h0040;
  localparam logic [OFS_W-1:0] PRESET_16   = 13'h0010;
  localparam logic [OFS_W-1:0] PRESET_8    = 13'h0008;
  localparam logic [OFS_W-1:0] PRESET_256  = 13'h0100;
  localparam logic [OFS_W-1:0] PRESET_1024 = 13'h0400;
  localparam logic [2:0] PARALLEL_LOADS = 3'h4;
  localparam int PARITY_SKIP_BIT = 8;

  typedef enum logic [1:0] {
    FOFL_PRESET   = 2'b00,
    FOFL_SERIAL   = 2'b01,
    FOFL_PARALLEL = 2'b11
  } fofl_mode_t;

  typedef enum logic [1:0] {
    FOFL_LOADING = 2'b00,
    FOFL_RUN     = 2'b01
  } fofl_state_t;

  typedef struct packed {
    logic [OFS_W-1:0] full1;
    logic [OFS_W-1:0] empty1;
    logic [OFS_W-1:0] full2;
    logic [OFS_W-1:0] empty2;
  } fofl_offsets_t;
endpackage : fofl_pkg

// >>> verilog/fofl_fifo.sv
// generic valid/ready FIFO
`timescale 1ns/10ps
module fofl_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             nrst,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule : fofl_fifo

// >>> verilog/fofl_top.sv
// flag offset loading and port A access decode
`timescale 1ns/10ps
module fofl_top import fofl_pkg::*; #(
  parameter int OW    = 13,
  parameter int DW    = 36,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic          mclk,
  input  wire logic          nrst,
  // configuration pins
  input  wire logic          master_reset_1,
  input  wire logic          master_reset_2,
  input  wire logic          flag_sel2,
  input  wire logic          flag_sel1_serial_enable,
  input  wire logic          flag_sel0_serial_data,
  // port A
  input  wire logic          port_a_select,
  input  wire logic          port_a_direction,
  input  wire logic          port_a_enable,
  input  wire logic          port_a_mailbox_sel,
  input  wire logic [DW-1:0] port_a_data_in,
  output logic      [DW-1:0] port_a_data_out,
  output logic               port_a_data_oe,
  // FIFO2 and mailbox 2 source toward port A
  input  wire logic [DW-1:0] fifo2_data,
  input  wire logic          fifo2_valid,
  output logic               fifo2_read,
  input  wire logic [DW-1:0] mailbox2_data,
  output logic               mailbox2_read,
  output logic               mailbox2_full_n,
  // FIFO1 data and mailbox 1 toward core
  output logic               fifo1_valid,
  input  wire logic          fifo1_ready,
  output logic      [DW-1:0] fifo1_data,
  output logic               mailbox1_write,
  output logic      [DW-1:0] mailbox1_data,
  // flags and offsets
  output logic               port_a_full_ready,
  output logic               port_b_full_ready,
  output fofl_offsets_t      offsets,
  output fofl_mode_t         load_mode,
  output logic               interspersed_parity_mode
);
  // ****************************************
  // reset edge capture
  // ****************************************
  logic        master_reset_1_q;
  logic        master_reset_2_q;
  logic        rise1;
  logic        rise2;
  logic        both_rise;
  logic [2:0]  fsel;
  fofl_state_t state;
  logic [2:0]  par_cnt;
  logic [5:0]  ser_cnt;
  logic [5:0]  ser_bits;
  logic        ser_done;
  logic        buf_in_ready;
  logic        fifo1_strobe;
  logic        mb_strobe;
  logic        in_reset;
  logic [OW-1:0] par_value;
  logic [OW-1:0] preset;

  assign rise1     = master_reset_1 & ~master_reset_1_q;
  assign rise2     = master_reset_2 & ~master_reset_2_q;
  assign both_rise = rise1 & rise2;
  // readies stay low until the release edge has been taken, so no stale mode shows
  assign in_reset  = ~master_reset_1 | ~master_reset_2 | rise1 | rise2;
  assign fsel      = {flag_sel2, flag_sel1_serial_enable, flag_sel0_serial_data};

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      // idle pin level, so leaving nrst is not taken as a release
      master_reset_1_q <= 1'b1;
      master_reset_2_q <= 1'b1;
    end else begin
      master_reset_1_q <= master_reset_1;
      master_reset_2_q <= master_reset_2;
    end
  end

  always_comb begin
    case (fsel)
      3'b111:  preset = OW'(PRESET_64);
      3'b110:  preset = OW'(PRESET_16);
      3'b101:  preset = OW'(PRESET_8);
      3'b011:  preset = OW'(PRESET_256);
      3'b001:  preset = OW'(PRESET_1024);
      default: preset = OW'(PRESET_64);
    endcase
  end

  // ****************************************
  // mode latch
  // ****************************************
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      load_mode                <= FOFL_PRESET;
      interspersed_parity_mode <= 1'b0;
    end else if (both_rise && fsel[1:0] == 2'b00) begin
      load_mode                <= FOFL_PARALLEL;
      interspersed_parity_mode <= ~flag_sel2;
    end else if (both_rise && fsel == 3'b010) begin
      load_mode                <= FOFL_SERIAL;
      interspersed_parity_mode <= 1'b0;
    end else if (rise1 || rise2) begin
      load_mode                <= FOFL_PRESET;
      interspersed_parity_mode <= 1'b0;
    end
  end

  // ****************************************
  // port A decode
  // ****************************************
  // bus faces in when deselected or writing; drives only on select low, direction low
  assign port_a_data_oe  = ~port_a_select & ~port_a_direction;
  assign fifo1_strobe    = ~port_a_select & port_a_enable & ~port_a_mailbox_sel
                           & port_a_direction & port_a_full_ready;
  assign mb_strobe       = ~port_a_select & port_a_enable & port_a_mailbox_sel;
  assign fifo2_read      = ~port_a_select & port_a_enable & ~port_a_mailbox_sel
                           & ~port_a_direction & fifo2_valid;
  assign mailbox2_read   = mb_strobe & ~port_a_direction;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      port_a_data_out <= '0;
      mailbox1_write  <= 1'b0;
      mailbox1_data   <= '0;
      mailbox2_full_n <= 1'b1;
    end else begin
      mailbox1_write <= mb_strobe & port_a_direction;
      if (mb_strobe && port_a_direction) begin
        mailbox1_data <= port_a_data_in;
      end
      if (mailbox2_read) begin
        port_a_data_out <= mailbox2_data;
        mailbox2_full_n <= 1'b1;
      end else if (fifo2_read) begin
        port_a_data_out <= fifo2_data;
      end
    end
  end

  // ****************************************
  // offset loading
  // ****************************************
  generate
    if (OW == 11) begin : g_w11
      assign par_value = interspersed_parity_mode ?
        {port_a_data_in[11:9], port_a_data_in[7:0]} : port_a_data_in[10:0];
    end else if (OW == 12) begin : g_w12
      assign par_value = interspersed_parity_mode ?
        {port_a_data_in[12:9], port_a_data_in[7:0]} : port_a_data_in[11:0];
    end else begin : g_w13
      assign par_value = interspersed_parity_mode ?
        {port_a_data_in[13:9], port_a_data_in[PARITY_SKIP_BIT-1:0]}
        : port_a_data_in[OW-1:0];
    end
  endgenerate

  assign ser_bits = 6'(4 * OW);
  assign ser_done = (ser_cnt == ser_bits);

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state   <= FOFL_LOADING;
      par_cnt <= '0;
      ser_cnt <= '0;
      offsets <= '0;
    end else if (rise1 || rise2) begin
      par_cnt <= '0;
      ser_cnt <= '0;
      state   <= (both_rise && (fsel[1:0] == 2'b00 || fsel == 3'b010)) ?
                 FOFL_LOADING : FOFL_RUN;
      if (rise1) begin
        offsets.full1  <= 13'(preset);
        offsets.empty1 <= 13'(preset);
      end
      if (rise2) begin
        offsets.full2  <= 13'(preset);
        offsets.empty2 <= 13'(preset);
      end
    end else if (state == FOFL_LOADING && !in_reset) begin
      case (load_mode)
        FOFL_PARALLEL: begin
          if (!port_a_select && port_a_enable && !port_a_mailbox_sel && port_a_direction) begin
            case (par_cnt)
              3'h0:    offsets.full1  <= 13'(par_value);
              3'h1:    offsets.empty1 <= 13'(par_value);
              3'h2:    offsets.full2  <= 13'(par_value);
              default: offsets.empty2 <= 13'(par_value);
            endcase
            par_cnt <= par_cnt + 3'h1;
            if (par_cnt == PARALLEL_LOADS - 3'h1) begin
              state <= FOFL_RUN;
            end
          end
        end
        FOFL_SERIAL: begin
          if (ser_done) begin
            state <= FOFL_RUN;
          end else if (!flag_sel1_serial_enable) begin
            // one long shift register, msb of full1 enters first
            offsets <= {offsets[4*OW-2:0], flag_sel0_serial_data};
            ser_cnt <= ser_cnt + 6'h1;
          end
        end
        default: state <= FOFL_LOADING; // no master reset taken yet
      endcase
    end
  end

  // ready flags low through reset and offset loading
  assign port_a_full_ready = (state == FOFL_RUN) & ~in_reset & buf_in_ready;
  assign port_b_full_ready = (state == FOFL_RUN) & ~in_reset;

  // ****************************************
  // FIFO1 write buffer
  // ****************************************
  // stalled drain pulls port_a_full_ready low, so writes never drop
  fofl_fifo #(.WIDTH(DW), .DEPTH(DEPTH)) u_buf (
    .mclk      (mclk),
    .nrst      (nrst),
    .in_valid  (fifo1_strobe),
    .in_ready  (buf_in_ready),
    .in_data   (port_a_data_in),
    .out_valid (fifo1_valid),
    .out_ready (fifo1_ready),
    .out_data  (fifo1_data)
  );
endmodule : fofl_top

// >>> testbench/fofl_top_props.sv
// checker for port A decode and offset load timing
`timescale 1ns/10ps
module fofl_top_props import fofl_pkg::*; #(
  parameter int DW = 36
) (
  // clock and reset
  input wire logic          mclk,
  input wire logic          nrst,
  // pins and port A strobes
  input wire logic          master_reset_1,
  input wire logic          master_reset_2,
  input wire logic          port_a_select,
  input wire logic          port_a_direction,
  input wire logic          port_a_enable,
  input wire logic          port_a_mailbox_sel,
  input wire logic [DW-1:0] port_a_data_in,
  // design outputs, and the fifo2_valid input
  input wire logic          port_a_data_oe,
  input wire logic          fifo2_valid,
  input wire logic          fifo2_read,
  input wire logic          mailbox2_read,
  input wire logic          mailbox2_full_n,
  input wire logic          mailbox1_write,
  input wire logic [DW-1:0] mailbox1_data,
  input wire logic          port_a_full_ready,
  input wire logic          port_b_full_ready,
  input wire fofl_offsets_t offsets,
  input wire fofl_mode_t    load_mode
);
  logic go;
  assign go = !port_a_select && port_a_enable;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // ****************************************
  // assertions
  // ****************************************
  oe_decode_a: assert property (port_a_data_oe == (!port_a_select && !port_a_direction))
    else $error("port A drive enable wrong");
  mbox_write_a: assert property (go && port_a_mailbox_sel && port_a_direction |=>
    mailbox1_write && mailbox1_data == $past(port_a_data_in)) else $error("mailbox 1 write lost");
  mbox_read_a: assert property (mailbox2_read |-> go && port_a_mailbox_sel &&
    !port_a_direction ##1 mailbox2_full_n) else $error("mailbox 2 read wrong");
  fifo2_read_a: assert property (fifo2_read |-> go && !port_a_mailbox_sel &&
    !port_a_direction && fifo2_valid) else $error("spurious FIFO2 read");
  hold_reset_a: assert property (!master_reset_1 || !master_reset_2 |->
    !port_a_full_ready && !port_b_full_ready) else $error("ready during master reset");
  par_done_a: assert property ($rose(port_b_full_ready) && load_mode == FOFL_PARALLEL |->
    $past(go && !port_a_mailbox_sel && port_a_direction)) else $error("ready not after write");
  ser_done_a: assert property ($rose(port_a_full_ready) && load_mode == FOFL_SERIAL |->
    $rose(port_b_full_ready)) else $error("port B ready late after serial load");
  ofs_hold_a: assert property (port_b_full_ready && $past(port_b_full_ready) |->
    $stable(offsets)) else $error("offsets changed in operation");
endmodule : fofl_top_props

bind fofl_top fofl_top_props #(.DW(DW)) u_props (
  .mclk(mclk), .nrst(nrst), .master_reset_1(master_reset_1), .master_reset_2(master_reset_2),
  .port_a_select(port_a_select), .port_a_direction(port_a_direction),
  .port_a_enable(port_a_enable), .port_a_mailbox_sel(port_a_mailbox_sel),
  .port_a_data_in(port_a_data_in), .port_a_data_oe(port_a_data_oe),
  .fifo2_valid(fifo2_valid), .fifo2_read(fifo2_read), .mailbox2_read(mailbox2_read),
  .mailbox2_full_n(mailbox2_full_n), .mailbox1_write(mailbox1_write),
  .mailbox1_data(mailbox1_data), .port_a_full_ready(port_a_full_ready),
  .port_b_full_ready(port_b_full_ready), .offsets(offsets), .load_mode(load_mode)
);

// >>> testbench/fofl_core_model.sv
// core side model: FIFO2 and mailbox 2 source, FIFO1 sink
`timescale 1ns/10ps
module fofl_core_model (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        nrst,
  // bench control
  input  wire logic        stall,
  // FIFO2 and mailbox 2 source
  output logic      [35:0] fifo2_data,
  output logic             fifo2_valid,
  input  wire logic        fifo2_read,
  output logic      [35:0] mailbox2_data,
  // FIFO1 sink
  input  wire logic        fifo1_valid,
  output logic             fifo1_ready,
  input  wire logic [35:0] fifo1_data
);
  logic [35:0] got[$];
  logic [7:0]  idx;
  // word only advances when taken, so the bench can predict it
  assign fifo2_valid   = 1'b1;
  assign fifo2_data    = 36'hC0DE00000 + {28'h0000000, idx};
  assign mailbox2_data = 36'h5A5A5A5A5;
  assign fifo1_ready   = !stall;
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) idx <= 8'h00;
    else if (fifo2_read) idx <= idx + 8'h01;
  end
  always @(posedge mclk) begin
    if (fifo1_valid && fifo1_ready) got.push_back(fifo1_data);
  end
endmodule : fofl_core_model

// >>> testbench/fofl_top_tb.sv
// self-checking bench for offset loading and port A decode
`timescale 1ns/10ps
module fofl_top_tb import fofl_pkg::*; ;
  logic mclk = 1'b0, nrst = 1'b0, mr1 = 1'b1, mr2 = 1'b1, s2 = 1'b0, s1 = 1'b1, s0 = 1'b0;
  logic sel_n = 1'b1, dir = 1'b1, en = 1'b0, mb = 1'b0, stall = 1'b1;
  logic [35:0] din = 36'h000000000, dout, f2d, m2d, f1d, m1d;
  logic oe, f2v, f2r, m2r, m2f, f1v, f1r, m1w, rdya, rdyb, ipm;
  logic [12:0] w;
  fofl_offsets_t ofs;
  fofl_mode_t    mode;
  int miscompares = 0;
  int n_compared = 0;
  logic [2:0]  pc[5] = '{3'b111, 3'b110, 3'b101, 3'b011, 3'b001};
  logic [12:0] pv[5] = '{PRESET_64, PRESET_16, PRESET_8, PRESET_256, PRESET_1024};
  logic [51:0] ov = {13'h1FFC, 13'h0001, 13'h0ABC, 13'h1234};
  logic [51:0] ov2 = {13'h1555, 13'h0AAA, 13'h0100, 13'h1FFC};
  always #25 mclk = ~mclk;
  fofl_top uut (.mclk(mclk), .nrst(nrst), .master_reset_1(mr1), .master_reset_2(mr2),
    .flag_sel2(s2), .flag_sel1_serial_enable(s1), .flag_sel0_serial_data(s0),
    .port_a_select(sel_n), .port_a_direction(dir), .port_a_enable(en),
    .port_a_mailbox_sel(mb), .port_a_data_in(din), .port_a_data_out(dout),
    .port_a_data_oe(oe), .fifo2_data(f2d), .fifo2_valid(f2v), .fifo2_read(f2r),
    .mailbox2_data(m2d), .mailbox2_read(m2r), .mailbox2_full_n(m2f), .fifo1_valid(f1v),
    .fifo1_ready(f1r), .fifo1_data(f1d), .mailbox1_write(m1w), .mailbox1_data(m1d),
    .port_a_full_ready(rdya), .port_b_full_ready(rdyb), .offsets(ofs), .load_mode(mode),
    .interspersed_parity_mode(ipm));
  fofl_core_model u_core (.mclk(mclk), .nrst(nrst), .stall(stall), .fifo2_data(f2d),
    .fifo2_valid(f2v), .fifo2_read(f2r), .mailbox2_data(m2d), .fifo1_valid(f1v),
    .fifo1_ready(f1r), .fifo1_data(f1d));
  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic mres(input logic a, input logic b, input logic c);
    @(posedge mclk);
    {mr1, mr2, s2, s1, s0} <= {2'b00, a, b, c};
    repeat (2) @(posedge mclk);
    {mr1, mr2} <= 2'b11;
    repeat (2) @(posedge mclk);
  endtask : mres
  task automatic pa(input logic d, input logic m, input logic [35:0] v);
    @(posedge mclk);
    {sel_n, en, dir, mb} <= {2'b01, d, m};
    din <= v;
  endtask : pa
  task automatic idle;
    @(posedge mclk);
    {sel_n, en} <= 2'b10;
  endtask : idle
  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    conclude();
  end
  initial begin
    repeat (12) @(posedge mclk);
    nrst <= 1'b1;
    @(negedge mclk);
    chk({ofs, rdya, rdyb, m2f}, 55'h1);
    for (int i = 0; i < 5; i++) begin
      mres(pc[i][2], pc[i][1], pc[i][0]);
      repeat (2) @(negedge mclk);
      chk({ofs, mode, rdya, rdyb}, {{4{pv[i]}}, FOFL_PRESET, 2'b11});
    end
    mres(1'b1, 1'b0, 1'b0);
    @(negedge mclk);
    chk({rdya, rdyb, ipm, mode}, {3'b000, FOFL_PARALLEL});
    for (int k = 3; k >= 0; k--) pa(1'b1, 1'b0, 36'hFFFFFE000 | ov[k*13 +: 13]);
    idle();
    @(negedge mclk);
    chk({ofs, rdya, rdyb}, {ov, 2'b11});
    for (int k = 0; k < 9; k++) pa(1'b1, 1'b0, 36'h100 + k);
    idle();
    @(negedge mclk);
    chk(rdya, 1'b0);
    @(posedge mclk);
    stall <= 1'b0;
    for (int t = 0; t < 40 && u_core.got.size() < 9; t++) @(posedge mclk);
    chk(u_core.got.size(), 8);
    for (int k = 0; k < 8; k++) chk(u_core.got[k], 36'h100 + k);
    pa(1'b1, 1'b1, 36'h9ABCDEF01);
    idle();
    @(negedge mclk);
    chk({m1w, m1d}, {1'b1, 36'h9ABCDEF01});
    pa(1'b0, 1'b0, 36'h000000000);
    @(negedge mclk);
    chk({oe, f2r}, 2'b11);
    pa(1'b0, 1'b1, 36'h000000000);
    @(negedge mclk);
    chk({dout, m2r}, {36'hC0DE00000, 1'b1});
    idle();
    @(negedge mclk);
    chk({dout, m2f, oe}, {36'h5A5A5A5A5, 2'b10});
    mres(1'b0, 1'b0, 1'b0);
    for (int k = 3; k >= 0; k--) begin
      w = ov2[k*13 +: 13];
      pa(1'b1, 1'b0, {22'h3FFFFF, w[12:8], 1'b1, w[7:0]});
    end
    idle();
    @(negedge mclk);
    chk({ofs, ipm}, {ov2, 1'b1});
    mres(1'b0, 1'b1, 1'b0);
    for (int k = 51; k >= 0; k--) begin
      @(posedge mclk);
      {s1, s0} <= {1'b0, ov[k]};
    end
    @(negedge mclk);
    chk({rdya, rdyb}, 2'b00);
    @(posedge mclk);
    s1 <= 1'b1;
    @(posedge mclk);
    @(negedge mclk);
    chk({ofs, rdya, rdyb, mode}, {ov, 2'b11, FOFL_SERIAL});
    conclude();
  end
endmodule : fofl_top_tb
